// ===== logic/cmp_pkg.sv
// constants shared by the comparator mode and interrupt control logic
// assumes an 8-bit special-function register port with paged access
package cmp_pkg;
    localparam int          NUM_CMP         = 3;
    localparam int          DATA_W          = 8;
    localparam int          ADDR_W          = 8;
    // paged per-comparator registers, page 1..3 selects comparator 0..2
    localparam logic [7:0]  ADDR_CTRL       = 8'h88;
    localparam logic [7:0]  ADDR_MODE       = 8'h89;
    localparam logic [7:0]  PAGE_CMP0       = 8'h01;
    // global registers, page 0
    localparam logic [7:0]  PAGE_GLOBAL     = 8'h00;
    localparam logic [7:0]  ADDR_XIE        = 8'hC0;
    localparam logic [7:0]  ADDR_IRQ_STATUS = 8'hC1;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'hC2;
    // mode register layout
    localparam int          MODE_RIE_BIT    = 5;
    localparam int          MODE_FIE_BIT    = 4;
    localparam int          MODE_FLD_LSB    = 0;
    localparam logic [7:0]  MODE_WMASK      = 8'h33;
    localparam logic [7:0]  MODE_RESET      = 8'h02;
    // control register layout
    localparam int          CTRL_ON_BIT     = 7;
    localparam int          CTRL_OUT_BIT    = 6;
    localparam int          CTRL_RIF_BIT    = 5;
    localparam int          CTRL_FIF_BIT    = 4;
    // cycles after reset before synchronised samples are trusted; the previous-sample
    // register only holds a real pin value after three edges, fewer gives a false edge
    localparam logic [1:0]  SETTLE_CYCLES   = 2'h3;
endpackage

// ===== logic/cmp_sync.sv
// two-stage synchroniser for the asynchronous comparator results
// assumes one system clock; first stage feeds only the second
`timescale 1ns/10ps
module cmp_sync
(
    input  wire logic                          clock,    // system clock
    input  wire logic                          arst_n,   // async reset, active low
    input  wire logic [cmp_pkg::NUM_CMP-1:0]   async_in, // raw comparator outputs
    output logic      [cmp_pkg::NUM_CMP-1:0]   sync_out  // synchronised outputs
);
    import cmp_pkg::*;

    logic [NUM_CMP-1:0] meta_r;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ===== logic/comparator_mode_irq_ctrl.sv
// control logic of three analog comparators: mode registers, edge flags, interrupts
// assumes a one-cycle register port on the system clock and a page input from the same domain
`timescale 1ns/10ps
module comparator_mode_irq_ctrl
(
    input  wire logic                                 clock,          // system clock, 100 MHz
    input  wire logic                                 arst_n,         // async reset, active low
    input  wire logic [7:0]                           sfr_page,       // active register page
    input  wire logic [cmp_pkg::ADDR_W-1:0]           addr,           // register address
    input  wire logic [cmp_pkg::DATA_W-1:0]           wdata,          // write data
    input  wire logic                                 wr_en,          // write strobe
    input  wire logic                                 rd_en,          // read strobe
    output logic      [cmp_pkg::DATA_W-1:0]           rdata,          // read data, cycle after rd_en
    input  wire logic [cmp_pkg::NUM_CMP-1:0]          comparator_raw, // async comparator outputs
    output logic      [cmp_pkg::NUM_CMP-1:0][1:0]     response_mode,  // response time select
    output logic      [cmp_pkg::NUM_CMP-1:0]          comparator_on,  // comparator enables
    output logic      [cmp_pkg::NUM_CMP-1:0]          pin_out,        // results toward port pins
    output logic      [cmp_pkg::NUM_CMP-1:0]          cmp_irq,        // per-comparator requests
    output logic                                      irq             // combined level interrupt
);
    import cmp_pkg::*;

    // one-hot comparator selected by page and address
    function automatic logic [NUM_CMP-1:0] cmp_select(input logic [7:0] page, input logic [7:0] a,
                                                      input logic [7:0] target);
        logic [NUM_CMP-1:0] sel;
        sel = '0;
        for (int i = 0; i < NUM_CMP; i++)
            sel[i] = (page == 8'(PAGE_CMP0 + 8'(i))) && (a == target);
        return sel;
    endfunction

    function automatic logic glb_select(input logic [7:0] page, input logic [7:0] a,
                                        input logic [7:0] target);
        return (page == PAGE_GLOBAL) && (a == target);
    endfunction

    logic [NUM_CMP-1:0][7:0] mode_r;
    logic [NUM_CMP-1:0]      on_r;
    logic [NUM_CMP-1:0]      rif_r;
    logic [NUM_CMP-1:0]      fif_r;
    logic [NUM_CMP-1:0]      xie_r;
    logic [NUM_CMP-1:0]      status_r;
    logic [NUM_CMP-1:0]      mask_r;
    logic [NUM_CMP-1:0]      result_sync;
    logic [NUM_CMP-1:0]      result_prev_r;
    logic [1:0]              settle_r;
    logic                    settled;
    logic [NUM_CMP-1:0]      mode_wr;
    logic [NUM_CMP-1:0]      ctrl_wr;
    logic [NUM_CMP-1:0]      mode_sel;
    logic [NUM_CMP-1:0]      ctrl_sel;
    logic [NUM_CMP-1:0]      rise_pulse;
    logic [NUM_CMP-1:0]      fall_pulse;
    logic [NUM_CMP-1:0]      rise_en;
    logic [NUM_CMP-1:0]      fall_en;
    logic [NUM_CMP-1:0]      new_req;
    logic                    status_rd;
    logic [DATA_W-1:0]       rd_mux;
    logic [DATA_W-1:0]       rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    assign mode_sel  = cmp_select(sfr_page, addr, ADDR_MODE);
    assign ctrl_sel  = cmp_select(sfr_page, addr, ADDR_CTRL);
    assign mode_wr   = wr_en ? mode_sel : '0;
    assign ctrl_wr   = wr_en ? ctrl_sel : '0;
    assign status_rd = rd_en && glb_select(sfr_page, addr, ADDR_IRQ_STATUS);

    ////////////////////////////////////////////////////////////////////////////////
    // mode registers

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            mode_r <= {NUM_CMP{MODE_RESET}};
        else
        begin
            for (int i = 0; i < NUM_CMP; i++)
                if (mode_wr[i])
                    mode_r[i] <= wdata & MODE_WMASK;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_CMP; i++)
        begin
            response_mode[i] = mode_r[i][MODE_FLD_LSB +: 2];
            rise_en[i]       = mode_r[i][MODE_RIE_BIT];
            fall_en[i]       = mode_r[i][MODE_FIE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // result synchronisation and edge detection

    cmp_sync u_sync
    (
        .clock    (clock),
        .arst_n   (arst_n),
        .async_in (comparator_raw),
        .sync_out (result_sync)
    );

    // blocks a false edge while the previous-sample register still holds its reset value
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            settle_r <= '0;
        else if (settle_r != SETTLE_CYCLES)
            settle_r <= settle_r + 2'h1;
    end

    assign settled = (settle_r == SETTLE_CYCLES);

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            result_prev_r <= '0;
        else
            result_prev_r <= result_sync;
    end

    assign rise_pulse = settled ? (result_sync & ~result_prev_r) : '0;
    assign fall_pulse = settled ? (~result_sync & result_prev_r) : '0;

    ////////////////////////////////////////////////////////////////////////////////
    // control: enable and sticky edge flags, a set wins over a software clear

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            on_r  <= '0;
            rif_r <= '0;
            fif_r <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_CMP; i++)
            begin
                if (ctrl_wr[i])
                    on_r[i] <= wdata[CTRL_ON_BIT];
                rif_r[i] <= rise_pulse[i] | (ctrl_wr[i] ? wdata[CTRL_RIF_BIT] : rif_r[i]);
                fif_r[i] <= fall_pulse[i] | (ctrl_wr[i] ? wdata[CTRL_FIF_BIT] : fif_r[i]);
            end
        end
    end

    assign comparator_on = on_r;
    assign pin_out       = on_r & result_sync;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts

    assign cmp_irq = xie_r & ((rif_r & rise_en) | (fif_r & fall_en));
    assign new_req = xie_r & ((rise_pulse & rise_en) | (fall_pulse & fall_en));

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            xie_r  <= '0;
            mask_r <= '0;
        end
        else
        begin
            if (wr_en && glb_select(sfr_page, addr, ADDR_XIE))
                xie_r <= wdata[NUM_CMP-1:0];
            if (wr_en && glb_select(sfr_page, addr, ADDR_IRQ_MASK))
                mask_r <= wdata[NUM_CMP-1:0];
        end
    end

    // read clears, but an event in the same cycle survives
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            status_r <= '0;
        else
            status_r <= new_req | (status_rd ? '0 : status_r);
    end

    assign irq = |(status_r & mask_r);

    ////////////////////////////////////////////////////////////////////////////////
    // read path, data valid only in the cycle after the strobe

    always_comb
    begin
        rd_mux = '0;
        if (glb_select(sfr_page, addr, ADDR_XIE))
            rd_mux = DATA_W'(xie_r);
        else if (glb_select(sfr_page, addr, ADDR_IRQ_STATUS))
            rd_mux = DATA_W'(status_r);
        else if (glb_select(sfr_page, addr, ADDR_IRQ_MASK))
            rd_mux = DATA_W'(mask_r);
        else
        begin
            for (int i = 0; i < NUM_CMP; i++)
            begin
                if (mode_sel[i])
                    rd_mux = mode_r[i] & MODE_WMASK;
                else if (ctrl_sel[i])
                begin
                    rd_mux[CTRL_ON_BIT]  = on_r[i];
                    rd_mux[CTRL_OUT_BIT] = result_sync[i];
                    rd_mux[CTRL_RIF_BIT] = rif_r[i];
                    rd_mux[CTRL_FIF_BIT] = fif_r[i];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rdata_r <= '0;
        else
            rdata_r <= rd_en ? rd_mux : '0;
    end

    assign rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic mode_written_r;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            mode_written_r <= 1'b0;
        else if (|mode_wr)
            mode_written_r <= 1'b1;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_reserved_zero: assert property (
        (((mode_r[0] | mode_r[1] | mode_r[2]) & ~MODE_WMASK) == 8'h00))
        else $error("reserved mode bits not zero");
    a_rise_gated: assert property (
        (rise_pulse[1] && !rise_en[1] && !status_rd) |=> (status_r[1] == $past(status_r[1])))
        else $error("rising edge raised request while disabled");
    a_fall_gated: assert property (
        (fall_pulse[1] && !fall_en[1] && !status_rd) |=> (status_r[1] == $past(status_r[1])))
        else $error("falling edge raised request while disabled");
    a_rise_sets: assert property (
        (rise_pulse[1] && rise_en[1] && xie_r[1]) |=> status_r[1])
        else $error("enabled rising edge lost");
    a_mode_drive: assert property (
        mode_wr[2] |=> (response_mode[2] == $past(wdata[1:0])))
        else $error("response mode not taken from write");
    a_reset_mode: assert property (
        !mode_written_r |-> (mode_r[1] == MODE_RESET))
        else $error("mode register reset value wrong");
    a_page_select: assert property (
        (wr_en && addr == ADDR_MODE && sfr_page == 8'h02) |=> (mode_r[0] == $past(mode_r[0])))
        else $error("wrong page wrote comparator 0 mode");
    // one cycle at a time: a later write may legally clear the flag
    a_flag_sticky: assert property (
        (rif_r[1] && !ctrl_wr[1]) |=> rif_r[1])
        else $error("rising flag dropped without write");
    a_xie_gate: assert property (
        (!xie_r[1] && !status_rd) |=> (status_r[1] == $past(status_r[1])))
        else $error("interrupt forwarded without extended enable");
    a_pin_low: assert property (
        !on_r[1] |-> !pin_out[1])
        else $error("disabled comparator drives pin high");
    a_one_edge: assert property (
        rise_pulse[1] |=> !rise_pulse[1] && !fall_pulse[1])
        else $error("transition flagged twice");
    a_read_latency: assert property (
        !rd_en |=> (rdata == 8'h00))
        else $error("read data outside answer cycle");

    c_rise_irq:   cover property (new_req[0] ##1 irq);
    c_fall_event: cover property (fall_pulse[2] && fall_en[2] && xie_r[2]);
    c_read_clear: cover property (status_r[1] && status_rd ##1 !status_r[1]);
    c_page_write: cover property (mode_wr[2] ##1 rd_en);
endmodule

// ===== dv/comparator_mode_irq_ctrl_tb_top.sv
// self-checking bench for the comparator mode and interrupt control block
// assumes the block's one-cycle register port; the bench drives every input directly
`timescale 1ns/10ps
module comparator_mode_irq_ctrl_tb_top;
    import cmp_pkg::*;

    logic                           clock;
    logic                           arst_n;
    logic [7:0]                     sfr_page;
    logic [ADDR_W-1:0]              addr;
    logic [DATA_W-1:0]              wdata;
    logic                           wr_en;
    logic                           rd_en;
    logic [DATA_W-1:0]              rdata;
    logic [NUM_CMP-1:0]             comparator_raw;
    logic [NUM_CMP-1:0][1:0]        response_mode;
    logic [NUM_CMP-1:0]             comparator_on;
    logic [NUM_CMP-1:0]             pin_out;
    logic [NUM_CMP-1:0]             cmp_irq;
    logic                           irq;
    int                             errors;
    int                             comparisons;
    int                             cycles;

    comparator_mode_irq_ctrl comparator_mode_irq_ctrl_i
    (
        .clock          (clock),
        .arst_n         (arst_n),
        .sfr_page       (sfr_page),
        .addr           (addr),
        .wdata          (wdata),
        .wr_en          (wr_en),
        .rd_en          (rd_en),
        .rdata          (rdata),
        .comparator_raw (comparator_raw),
        .response_mode  (response_mode),
        .comparator_on  (comparator_on),
        .pin_out        (pin_out),
        .cmp_irq        (cmp_irq),
        .irq            (irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // the whole sequence needs under 150 cycles; this ceiling only catches hangs
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            errors = errors + 1;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] page, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_page <= page;
        addr     <= a;
        wdata    <= d;
        wr_en    <= 1'b1;
        @(posedge clock);
        wr_en    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] page, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        sfr_page <= page;
        addr     <= a;
        rd_en    <= 1'b1;
        @(posedge clock);
        rd_en    <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    // edges need two sync stages plus the flag edge; six cycles leaves margin
    task automatic drive_raw(input logic v);
        @(posedge clock);
        comparator_raw[1] <= v;
        repeat (6) @(posedge clock);
        #1;
    endtask

    task automatic close_out();
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        errors = 0;
        comparisons = 0;
        cycles = 0;
        arst_n = 1'b0;
        sfr_page = 8'h00;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        comparator_raw = 3'h0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        for (int c = 0; c < NUM_CMP; c++)
        begin
            check({6'h00, response_mode[c]}, 8'h02);
            rd(PAGE_CMP0 + 8'(c), ADDR_MODE, MODE_RESET);
        end
        // every mode on every comparator, different per page; reserved bits written high
        for (int m = 0; m < 4; m++)
        begin
            for (int c = 0; c < NUM_CMP; c++)
                wr(PAGE_CMP0 + 8'(c), ADDR_MODE, 8'hCC | 8'((m + c) % 4));
            for (int c = 0; c < NUM_CMP; c++)
            begin
                rd(PAGE_CMP0 + 8'(c), ADDR_MODE, 8'((m + c) % 4));
                check({6'h00, response_mode[c]}, 8'((m + c) % 4));
            end
        end
        rd(8'h04, ADDR_MODE, 8'h00);
        // comparator 1: rising edge enabled only
        wr(PAGE_GLOBAL, ADDR_XIE, 8'h02);
        wr(PAGE_GLOBAL, ADDR_IRQ_MASK, 8'h02);
        wr(8'h02, ADDR_CTRL, 8'h80);
        wr(8'h02, ADDR_MODE, 8'h20);
        drive_raw(1'b1);
        check({5'h00, comparator_on}, 8'h02);
        check({5'h00, pin_out}, 8'h02);
        check({5'h00, cmp_irq}, 8'h02);
        check({7'h00, irq}, 8'h01);
        rd(8'h02, ADDR_CTRL, 8'hE0);
        rd(PAGE_GLOBAL, ADDR_IRQ_STATUS, 8'h02);
        check({7'h00, irq}, 8'h00);
        drive_raw(1'b0);
        rd(8'h02, ADDR_CTRL, 8'hB0);
        rd(PAGE_GLOBAL, ADDR_IRQ_STATUS, 8'h00);
        wr(8'h02, ADDR_CTRL, 8'h80);
        #1;
        check({5'h00, cmp_irq}, 8'h00);
        rd(8'h02, ADDR_CTRL, 8'h80);
        // falling edge enabled only
        wr(8'h02, ADDR_MODE, 8'h10);
        drive_raw(1'b1);
        check({5'h00, cmp_irq}, 8'h00);
        rd(PAGE_GLOBAL, ADDR_IRQ_STATUS, 8'h00);
        drive_raw(1'b0);
        check({5'h00, cmp_irq}, 8'h02);
        check({7'h00, irq}, 8'h01);
        // extended enable withdrawn gates the request
        wr(PAGE_GLOBAL, ADDR_XIE, 8'h00);
        #1;
        check({5'h00, cmp_irq}, 8'h00);
        rd(PAGE_GLOBAL, ADDR_IRQ_STATUS, 8'h02);
        check({7'h00, irq}, 8'h00);
        // disabled comparator keeps its pin low
        wr(8'h02, ADDR_CTRL, 8'h00);
        drive_raw(1'b1);
        check({5'h00, pin_out}, 8'h00);
        check({5'h00, comparator_on}, 8'h00);
        // enabled falling edge with the extended enable off must not reach status
        drive_raw(1'b0);
        check({5'h00, cmp_irq}, 8'h00);
        rd(PAGE_GLOBAL, ADDR_IRQ_STATUS, 8'h00);
        close_out();
    end
endmodule
